// ---- verilog/nvsram_host.sv ----
// Host controller that runs read and write cycles on a nonvolatile SRAM.
`timescale 1ns/100ps
module nvsram_host
    import nvsram_host_pkg::*;
#(
    parameter int RECOVERY_CYC = RECOVERY_CYC_DEF
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic req_valid_in,
    input wire mem_req_s req_in,
    output logic req_ready_out,
    output logic rd_valid_out,
    output logic [DATA_W-1:0] rd_data_out,
    output logic [ADDR_W-1:0] word_select_lines_out,
    output strobe_s strobe_n_out,
    input wire logic [DATA_W-1:0] byte_lines_in,
    output logic [DATA_W-1:0] byte_lines_out,
    output logic byte_lines_oe_out,
    output logic write_ready_out
);
    typedef enum logic [2:0]
    {
        ST_IDLE = 3'b000,
        ST_W_SEL = 3'b001,
        ST_W_PULSE = 3'b011,
        ST_W_HOLD = 3'b010,
        ST_R_ACCESS = 3'b110,
        ST_GAP = 3'b111
    } state_e;

    ////////////////////////////////////////////////////////////////////////////
    logic [DATA_W-1:0] byte_sync;
    state_e state_reg, state_next;
    logic [7:0] cnt_reg, cnt_next;
    logic [CNT_W-1:0] rec_reg, rec_next;
    logic rec_done_reg, rec_done_next;
    logic [ADDR_W-1:0] addr_reg, addr_next;
    logic [DATA_W-1:0] wdata_reg, wdata_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic rd_valid_reg, rd_valid_next;
    logic oe_reg, oe_next;
    strobe_s strobe_reg, strobe_next;
    logic ready_reg, ready_next;

    // The data pins come from the device, so they are synchronised first.
    sync2 #(.WIDTH(DATA_W)) u_sync
    (
        .core_clk_in(core_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(byte_lines_in),
        .sync_out(byte_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        rec_next = rec_reg;
        rec_done_next = rec_done_reg;
        if (!rec_done_reg)
        begin
            if (rec_reg >= CNT_W'(RECOVERY_CYC - 1))
            begin
                rec_done_next = 1'b1;
            end
            else
            begin
                rec_next = rec_reg + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            rec_reg <= '0;
            rec_done_reg <= 1'b0;
        end
        else
        begin
            rec_reg <= rec_next;
            rec_done_reg <= rec_done_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // The read sample point sits one sync delay late; the extra two cycles
    // lengthen the read cycle but keep metastable data out of the result.
    always_comb
    begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        addr_next = addr_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        rd_valid_next = 1'b0;
        oe_next = oe_reg;
        strobe_next = strobe_reg;
        ready_next = 1'b0;
        unique case (state_reg)
            ST_IDLE:
            begin
                ready_next = 1'b1;
                if (req_valid_in && ready_reg && (!req_in.write || rec_done_reg))
                begin
                    ready_next = 1'b0;
                    addr_next = req_in.addr;
                    cnt_next = '0;
                    if (req_in.write)
                    begin
                        wdata_next = req_in.data;
                        state_next = ST_W_SEL;
                    end
                    else
                    begin
                        strobe_next = '{select_n: 1'b0, write_n: 1'b1, output_n: 1'b0};
                        state_next = ST_R_ACCESS;
                    end
                end
                else if (req_valid_in && req_in.write && !rec_done_reg)
                begin
                    // Once recovery ends, ready comes back so the held write is taken.
                    ready_next = 1'b0;
                end
            end
            ST_W_SEL:
            begin
                // Select, write strobe and data drive all go active together; output enable stays high.
                strobe_next = '{select_n: 1'b0, write_n: 1'b0, output_n: 1'b1};
                oe_next = 1'b1;
                state_next = ST_W_PULSE;
            end
            ST_W_PULSE:
            begin
                cnt_next = cnt_reg + 1'b1;
                // Select falls with the strobe, so the pulse must also cover select-to-end.
                if (cnt_reg >= 8'(WRITE_PULSE_CYC - 1) &&
                    cnt_reg >= 8'(SELECT_LOW_CYC - 1))
                begin
                    strobe_next.write_n = 1'b1;
                    cnt_next = '0;
                    state_next = ST_W_HOLD;
                end
            end
            ST_W_HOLD:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= 8'(WRITE_HOLD_CYC - 1))
                begin
                    strobe_next.select_n = 1'b1;
                    oe_next = 1'b0;
                    cnt_next = '0;
                    state_next = ST_GAP;
                end
            end
            ST_R_ACCESS:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= 8'(READ_ACCESS_CYC + 1))
                begin
                    rdata_next = byte_sync;
                    rd_valid_next = 1'b1;
                    strobe_next = '{select_n: 1'b1, write_n: 1'b1, output_n: 1'b1};
                    cnt_next = '0;
                    state_next = ST_GAP;
                end
            end
            ST_GAP:
            begin
                cnt_next = cnt_reg + 1'b1;
                if (cnt_reg >= 8'(FLOAT_CYC - 1))
                begin
                    ready_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            default:
            begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= '0;
            addr_reg <= ADDR_RESET;
            wdata_reg <= DATA_RESET;
            rdata_reg <= DATA_RESET;
            rd_valid_reg <= 1'b0;
            oe_reg <= 1'b0;
            strobe_reg <= '{select_n: 1'b1, write_n: 1'b1, output_n: 1'b1};
            ready_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            addr_reg <= addr_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            rd_valid_reg <= rd_valid_next;
            oe_reg <= oe_next;
            strobe_reg <= strobe_next;
            ready_reg <= ready_next;
        end
    end

    // Note needs no host logic; retention starts at first power.
    assign req_ready_out = ready_reg;
    assign rd_valid_out = rd_valid_reg;
    assign rd_data_out = rdata_reg;
    assign word_select_lines_out = addr_reg;
    assign strobe_n_out = strobe_reg;
    assign byte_lines_out = wdata_reg;
    assign byte_lines_oe_out = oe_reg;
    assign write_ready_out = rec_done_reg;
endmodule // nvsram_host

// ---- verilog/nvsram_host_pkg.sv ----
// Package of constants and carriers for the nonvolatile SRAM host controller.
package nvsram_host_pkg;
    localparam int ADDR_W = 21;
    localparam int DATA_W = 8;
    localparam int CLK_PERIOD_NS = 10;
    // Host-side timing minimums, in ns as printed, except the select recovery in ms.
    localparam int WRITE_PULSE_NS = 55;
    localparam int SELECT_TO_END_NS = 65;
    localparam int ADDR_TO_END_NS = 65;
    localparam int DATA_SETUP_NS = 30;
    localparam int WRITE_CYCLE_NS = 70;
    localparam int STROBE_RELEASE_RECOVERY_NS = 5;
    localparam int STROBE_DATA_HOLD_NS = 0;
    localparam int READ_CYCLE_NS = 70;
    localparam int SELECT_ACCESS_NS = 70;
    localparam int OUTPUT_FLOAT_NS = 25;
    localparam int SELECT_RECOVERY_MS = 120;
    function automatic int ceil_cycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int WRITE_PULSE_CYC = ceil_cycles(WRITE_PULSE_NS);
    localparam int SELECT_LOW_CYC = ceil_cycles(SELECT_TO_END_NS);
    localparam int WRITE_HOLD_CYC = ceil_cycles(STROBE_RELEASE_RECOVERY_NS);
    localparam int WRITE_CYCLE_CYC = ceil_cycles(WRITE_CYCLE_NS);
    localparam int READ_ACCESS_CYC = ceil_cycles(SELECT_ACCESS_NS);
    localparam int FLOAT_CYC = ceil_cycles(OUTPUT_FLOAT_NS);
    localparam int RECOVERY_CYC_DEF = SELECT_RECOVERY_MS * 100000;
    localparam int CNT_W = 24;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 21'h000000;
    localparam logic [DATA_W-1:0] DATA_RESET = 8'h00;

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } mem_req_s;

    typedef struct packed {
        logic select_n;
        logic write_n;
        logic output_n;
    } strobe_s;
endpackage

// ---- verilog/sync2.sv ----
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/100ps
module sync2
#(
    parameter int WIDTH = 8
)
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge core_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= async_in;
            sync_reg <= meta_reg;
        end
    end

    assign sync_out = sync_reg;
endmodule // sync2

// ---- dv/nvsram_host_asserts.sv ----
// Checker of the host-side pin timing of the nonvolatile SRAM controller.
`timescale 1ns/100ps
module nvsram_host_asserts
    import nvsram_host_pkg::*;
(
    input wire logic core_clk_in,
    input wire logic rst_n_in,
    input wire logic rd_valid_out,
    input wire logic [ADDR_W-1:0] word_select_lines_out,
    input wire strobe_s strobe_n_out,
    input wire logic [DATA_W-1:0] byte_lines_out,
    input wire logic byte_lines_oe_out,
    input wire logic write_ready_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (!rst_n_in);
    wire sel = strobe_n_out.select_n;
    wire wr = strobe_n_out.write_n;
    wire rd = strobe_n_out.output_n;
    ////////////////////////////////////////////////////////////////////////////////////
    a_addr_in_write: assert property (!sel && !wr |-> $stable(word_select_lines_out))
        else $error("address moved in write");
    a_oe_write_only: assert property (byte_lines_oe_out |-> rd && !sel)
        else $error("data driven outside write");
    a_pulse_width: assert property ($fell(wr) |-> (!wr) [*7] ##1 wr)
        else $error("write pulse length wrong");
    a_select_lead: assert property ($rose(wr) |-> !sel && !$past(sel, 7))
        else $error("select too short");
    a_data_steady: assert property (!wr || $rose(wr) |-> $stable(byte_lines_out))
        else $error("write data moved");
    a_addr_hold: assert property ($rose(wr) |=> $stable(word_select_lines_out))
        else $error("address not held");
    a_early_write: assert property (!write_ready_out |-> wr)
        else $error("write during recovery");
    a_read_answer: assert property ($fell(rd) |-> ##9 rd_valid_out)
        else $error("read answer late");
    c_write: cover property ($fell(wr));
    c_read: cover property (rd_valid_out);
    c_ready: cover property ($rose(write_ready_out));
endmodule // nvsram_host_asserts
bind nvsram_host nvsram_host_asserts chk (.core_clk_in, .rst_n_in, .rd_valid_out,
    .word_select_lines_out, .strobe_n_out, .byte_lines_out, .byte_lines_oe_out, .write_ready_out);

// ---- dv/nvsram_model.sv ----
// Behavioural model of the battery-backed static memory at the host's pins.
`timescale 1ns/100ps
module nvsram_model
    import nvsram_host_pkg::*;
#(
    parameter int ACCESS_NS = 65,
    parameter int PROTECT_NS = 300
)
(
    input wire logic [ADDR_W-1:0] addr_in,
    input wire strobe_s strobe_n_in,
    input wire logic [DATA_W-1:0] bus_in,
    output logic [DATA_W-1:0] data_out
);
    // Only the low address byte is decoded to keep the model small.
    logic [DATA_W-1:0] mem [0:255];
    logic [DATA_W-1:0] last = 8'h00;
    logic late = 1'b0;
    wire reading = !strobe_n_in.select_n && strobe_n_in.write_n && !strobe_n_in.output_n;
    wire both_low = !strobe_n_in.select_n && !strobe_n_in.write_n;
    initial
    begin
        for (int i = 0; i < 256; i++)
            mem[i] = i[7:0];
    end
    always @(reading)
        late <= #(ACCESS_NS) reading;
    // A released bus shows the inverse of the last byte so stale data never matches.
    assign data_out = (reading && late) ? mem[addr_in[7:0]] : ~last;
    always @(negedge reading)
        last = mem[addr_in[7:0]];
    // Protection counts from time zero, the first power-up.
    always @(negedge both_low)
        if ($time >= PROTECT_NS)
            mem[addr_in[7:0]] = bus_in;
endmodule // nvsram_model

// ---- dv/nvsram_host_test.sv ----
// Self-checking bench for the nonvolatile SRAM host controller.
`timescale 1ns/100ps
module nvsram_host_test
    import nvsram_host_pkg::*;
;
    logic core_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_valid_in = 1'b0;
    mem_req_s req_in = '0;
    logic req_ready_out, rd_valid_out, byte_lines_oe_out, write_ready_out;
    logic [DATA_W-1:0] rd_data_out, byte_lines_out, dev_data, bus_level;
    logic [ADDR_W-1:0] word_select_lines_out;
    strobe_s strobe_n_out;
    int failures = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #5 core_clk_in = ~core_clk_in;
    assign bus_level = byte_lines_oe_out ? byte_lines_out : dev_data;
    nvsram_host #(.RECOVERY_CYC(40)) uut (.core_clk_in, .rst_n_in, .req_valid_in, .req_in,
        .req_ready_out, .rd_valid_out, .rd_data_out, .word_select_lines_out, .strobe_n_out,
        .byte_lines_in(bus_level), .byte_lines_out, .byte_lines_oe_out, .write_ready_out);
    nvsram_model dev (.addr_in(word_select_lines_out), .strobe_n_in(strobe_n_out),
        .bus_in(bus_level), .data_out(dev_data));
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic complete_run();
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic tick();
        @(posedge core_clk_in);
        #1;
    endtask
    // A write stays pending while the controller holds it off; the timeout bounds that.
    task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        req_valid_in <= 1'b1;
        req_in <= '{write: wr, addr: a, data: d};
        do
            @(posedge core_clk_in);
        while (!(req_ready_out === 1'b1 && (!wr || write_ready_out === 1'b1)));
        req_valid_in <= 1'b0;
        tick();
        check("address pins", a, word_select_lines_out);
        if (!wr)
        begin
            n = 1;
            while (rd_valid_out !== 1'b1 && n < 20)
            begin
                tick();
                n++;
            end
            // Access time plus the two synchroniser stages on the data pins.
            check("read latency", READ_ACCESS_CYC + 2, n);
            check("read data", d, rd_data_out);
            tick();
            check("valid pulse", 1'b0, rd_valid_out);
        end
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    task automatic s_recovery();
        xfer(1'b0, 21'h000012, 8'h12);
        check("recovery flag", 1'b0, write_ready_out);
        xfer(1'b1, 21'h000012, 8'hC3);
        xfer(1'b0, 21'h000012, 8'hC3);
    endtask
    task automatic s_back_to_back();
        logic [ADDR_W-1:0] a [4] = '{21'h1FFFFF, 21'h100001, 21'h0000A5, 21'h000040};
        logic [DATA_W-1:0] d [4] = '{8'hFF, 8'h00, 8'h5A, 8'hA5};
        foreach (a[i])
            xfer(1'b1, a[i], d[i]);
        foreach (a[i])
            xfer(1'b0, a[i], d[i]);
    endtask
    task automatic s_reset();
        rst_n_in <= 1'b0;
        tick();
        check("idle strobes", 3'b111, strobe_n_out);
        check("recovery restart", 1'b0, write_ready_out);
        rst_n_in <= 1'b1;
        tick();
        xfer(1'b0, 21'h0000A5, 8'h5A);
    endtask
    ////////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (5) @(posedge core_clk_in);
        rst_n_in <= 1'b1;
        @(posedge core_clk_in);
        s_recovery();
        s_back_to_back();
        s_reset();
        complete_run();
    end
    always @(posedge core_clk_in)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            complete_run();
        end
    end
endmodule // nvsram_host_test
